// >>> rtl/serial_adc_regs.svh
`ifndef SERIAL_ADC_REGS_SVH
`define SERIAL_ADC_REGS_SVH

// clock and conversion timing
`define CLK_PERIOD_NS   20
`define CONV_TIME_NS    20000
`define CONV_CYCLES     ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// serial clock edge positions and bit counts within a transfer
`define ADDR_BITS       4
`define SAMPLE_START    5'h04
`define SAMPLE_END      5'h0a
`define FULL_XFER       5'h10
`define RESULT_BITS     10

// address codes
`define LAST_EXT_CHAN   4'ha
`define CODE_MID_REF    4'hb
`define CODE_LOW_REF    4'hc
`define CODE_HIGH_REF   4'hd

// reset values
`define RESULT_RESET    10'h000

`endif

// >>> rtl/serial_adc_pkg.sv
package serial_adc_pkg;
	typedef enum logic [0:0]
	{
		CONV_IDLE = 1'b0,
		CONV_RUN  = 1'b1
	} conv_state_type;

	typedef logic [9:0]  result_type;
	typedef logic [13:0] mux_type;
endpackage

// >>> rtl/pin_sync.sv
`timescale 1ns/10ps
`default_nettype none

module pin_sync
(
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       resetn,
	// raw pins
	input  wire logic [2:0] pinIn,
	// synchronised levels and edges
	output logic      [2:0] level,
	output logic      [2:0] rise,
	output logic      [2:0] fall
);
	logic [2:0] stage1;
	logic [2:0] stage2;
	logic [2:0] stage3;

	// two-flop synchroniser, plus a third stage for edge finding
	// reset to idle pin levels (select high, clock low) so no false edge follows reset
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			stage1 <= 3'h4;
			stage2 <= 3'h4;
			stage3 <= 3'h4;
		end
		else
		begin
			stage1 <= pinIn;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// edges seen only on synchronised stages
	assign level = stage2;
	assign rise  = stage2 & ~stage3;
	assign fall  = ~stage2 & stage3;
endmodule

`default_nettype wire

// >>> rtl/serial_adc_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`include "serial_adc_regs.svh"

module serial_adc_ctrl
(
	// clock and reset
	input  wire logic                       clk_sys,
	input  wire logic                       resetn,
	// serial pins
	input  wire logic                       selectN,
	input  wire logic                       serClk,
	input  wire logic                       addrIn,
	output logic                            dataOut,
	output logic                            dataOutOeN,
	output logic                            eocOut,
	// converter core side
	input  wire serial_adc_pkg::result_type convResult,
	output serial_adc_pkg::mux_type         muxSelect,
	output logic                            sampleEn,
	output logic                            convStart
);
	import serial_adc_pkg::*;

	localparam logic [15:0] CONV_LAST = 16'(`CONV_CYCLES - 1);

	logic [2:0] level;
	logic [2:0] rise;
	logic [2:0] fall;
	logic       selHigh;
	logic       selFall;
	logic       clkRise;
	logic       clkFall;
	logic       addrBit;

	conv_state_type convState;
	conv_state_type next_convState;
	logic [15:0]    convCnt;
	logic [15:0]    next_convCnt;
	logic [4:0]     riseCnt;
	logic [4:0]     next_riseCnt;
	logic [4:0]     fallCnt;
	logic [4:0]     next_fallCnt;
	logic [3:0]     addrShift;
	logic [3:0]     next_addrShift;
	mux_type        next_muxSelect;
	result_type     outShift;
	result_type     next_outShift;
	result_type     resultReg;
	result_type     next_resultReg;
	logic           doneEarly;
	logic           next_doneEarly;
	logic           next_sampleEn;
	logic           next_convStart;
	logic           next_eocOut;
	logic           restartNow;

	// channel code to one-hot mux enable, unused codes select nothing
	function automatic mux_type decodeChannel(input logic [3:0] code);
		mux_type sel;
		sel = '0;
		if (code <= `CODE_HIGH_REF)
			sel[code] = 1'b1;
		return sel;
	endfunction

	pin_sync u_sync
	(
		.clk_sys (clk_sys),
		.resetn  (resetn),
		.pinIn   ({selectN, serClk, addrIn}),
		.level   (level),
		.rise    (rise),
		.fall    (fall)
	);

	assign selHigh = level[2];
	assign selFall = fall[2];
	assign clkRise = rise[1] & ~selHigh;
	assign clkFall = fall[1] & ~selHigh;
	assign addrBit = level[0];

	// sequence, shift and conversion control
	always_comb
	begin
		next_convState = convState;
		next_convCnt   = convCnt;
		next_riseCnt   = riseCnt;
		next_fallCnt   = fallCnt;
		next_addrShift = addrShift;
		next_muxSelect = muxSelect;
		next_outShift  = outShift;
		next_resultReg = resultReg;
		next_doneEarly = doneEarly;
		next_sampleEn  = sampleEn;
		next_convStart = 1'b0;
		next_eocOut    = eocOut;
		restartNow     = 1'b0;
		if (selFall)
		begin
			// new transfer; an ongoing conversion is dropped
			next_riseCnt   = '0;
			next_fallCnt   = '0;
			next_outShift  = resultReg;
			next_sampleEn  = 1'b0;
			next_doneEarly = 1'b0;
			next_convState = CONV_IDLE;
			next_eocOut    = 1'b1;
		end
		else
		begin
			if (clkRise)
			begin
				if (riseCnt < 5'(`ADDR_BITS))
					next_addrShift = {addrShift[2:0], addrBit};
				if (riseCnt == 5'(`ADDR_BITS - 1))
					next_muxSelect = decodeChannel({addrShift[2:0], addrBit});
				if (riseCnt != 5'h1f)
					next_riseCnt = riseCnt + 5'h01;
			end
			if (clkFall)
			begin
				if (fallCnt != 5'h1f)
					next_fallCnt = fallCnt + 5'h01;
				if (fallCnt < 5'(`SAMPLE_END - 1))
					next_outShift = {outShift[8:0], 1'b0};
				if (fallCnt == `SAMPLE_START - 5'h01)
					next_sampleEn = 1'b1;
				if (fallCnt == `SAMPLE_END - 5'h01)
				begin
					// hand over to conversion
					next_sampleEn  = 1'b0;
					next_convStart = 1'b1;
					next_convState = CONV_RUN;
					next_convCnt   = '0;
					next_eocOut    = 1'b0;
					next_outShift  = '0;
				end
				if (fallCnt == `FULL_XFER - 5'h01 && doneEarly)
				begin
					// slow held-select: sixteenth fall begins next sequence
					next_riseCnt   = '0;
					next_fallCnt   = '0;
					next_outShift  = resultReg;
					next_doneEarly = 1'b0;
				end
			end
			if (convState == CONV_RUN)
			begin
				next_convCnt = convCnt + 16'h0001;
				if (convCnt == CONV_LAST)
				begin
					next_convState = CONV_IDLE;
					next_resultReg = convResult;
					next_eocOut    = 1'b1;
					if (!selHigh && (fallCnt == `SAMPLE_END || fallCnt == `FULL_XFER))
					begin
						// fast held-select: done edge begins next sequence
						restartNow    = 1'b1;
						next_riseCnt  = '0;
						next_fallCnt  = '0;
						next_outShift = convResult;
					end
					else if (!selHigh)
						next_doneEarly = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			convState  <= CONV_IDLE;
			convCnt    <= '0;
			riseCnt    <= '0;
			fallCnt    <= '0;
			addrShift  <= '0;
			muxSelect  <= '0;
			outShift   <= `RESULT_RESET;
			resultReg  <= `RESULT_RESET;
			doneEarly  <= 1'b0;
			sampleEn   <= 1'b0;
			convStart  <= 1'b0;
			eocOut     <= 1'b1;
			dataOutOeN <= 1'b1;
		end
		else
		begin
			convState  <= next_convState;
			convCnt    <= next_convCnt;
			riseCnt    <= next_riseCnt;
			fallCnt    <= next_fallCnt;
			addrShift  <= next_addrShift;
			muxSelect  <= next_muxSelect;
			outShift   <= next_outShift;
			resultReg  <= next_resultReg;
			doneEarly  <= next_doneEarly;
			sampleEn   <= next_sampleEn;
			convStart  <= next_convStart;
			eocOut     <= next_eocOut;
			dataOutOeN <= selHigh;
		end
	end

	assign dataOut = outShift[9];

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	addr_capture_a: assert property (clkRise && !selFall && riseCnt == 5'h03
		|=> muxSelect == decodeChannel({$past(addrShift[2:0]), $past(addrBit)}))
		else $error("channel not applied after fourth rise");
	sample_open_a: assert property (clkFall && !selFall && fallCnt == 5'h03
		|=> sampleEn ##1 sampleEn)
		else $error("sampling window did not open");
	conv_start_a: assert property (clkFall && !selFall && fallCnt == 5'h09
		|=> convStart && !eocOut && !dataOut && !sampleEn)
		else $error("tenth fall handover wrong");
	start_only_a: assert property (convStart |-> fallCnt == 5'h0a)
		else $error("conversion started early");
	hiz_hold_a: assert property (selHigh ##1 selHigh |-> dataOutOeN)
		else $error("output driven while deselected");
	sel_load_a: assert property (selFall |=> fallCnt == 5'h00 ##1 !dataOutOeN)
		else $error("select fall did not start transfer");
	shift_out_a: assert property (clkFall && !selFall && fallCnt < 5'h09 && !restartNow
		|=> dataOut == $past(outShift[8]))
		else $error("result bit not shifted");
	eoc_done_a: assert property (convState == CONV_RUN && convCnt == CONV_LAST && !selFall
		|=> eocOut && resultReg == $past(convResult))
		else $error("conversion end not flagged");
	restart_a: assert property (restartNow |=> fallCnt == 5'h00 && dataOut == resultReg[9])
		else $error("held-select restart wrong");
	abort_a: assert property (selFall |=> convState == CONV_IDLE && eocOut
		&& resultReg == $past(resultReg))
		else $error("abort did not keep result");
	ignore_clk_a: assert property (selHigh && !selFall |=> $stable(fallCnt) && $stable(riseCnt))
		else $error("clock counted while deselected");

	fast_cover: cover property (convStart ##[1:1000] restartNow);
	slow_cover: cover property (doneEarly ##[1:1000] (clkFall && fallCnt == 5'h0f));
	abort_cover: cover property (convState == CONV_RUN && selFall);
	deselect_cover: cover property ($rose(eocOut) && selHigh);
endmodule

`default_nettype wire

// >>> testbench/host_port.sv
`timescale 1ns/10ps
`default_nettype none

module host_port
(
	// clock
	input  wire logic clk_sys,
	// serial pins
	output logic      selectN,
	output logic      serClk,
	output logic      addrIn,
	input  wire logic dataOut
);
	logic [15:0] got;

	// idle: deselected, serial clock parked low
	initial
	begin
		selectN = 1'b1;
		serClk = 1'b0;
		addrIn = 1'b1;
		got = 16'h0000;
	end

	// wait n edges, then change just after the last one
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	// one transfer of n clocks; slow stretches clocks past the tenth
	task automatic xfer(input logic [3:0] a, input int n, input logic hold, input logic slow);
		int h;
		selectN = 1'b0;
		tick(8);
		for (int k = 1; k <= n; k++)
		begin
			h = (slow && k > 10) ? 200 : 4;
			addrIn = (k <= 4) ? a[4 - k] : ~addrIn;
			tick(h);
			serClk = 1'b1;
			got = {got[14:0], dataOut};
			tick(h);
			serClk = 1'b0;
		end
		tick(8);
		if (!hold)
			selectN = 1'b1;
		tick(8);
	endtask
endmodule

`default_nettype wire

// >>> testbench/test_serial_adc_interface_control.sv
`timescale 1ns/10ps
`default_nettype none
`include "serial_adc_regs.svh"

module test_serial_adc_interface_control;
	import serial_adc_pkg::*;
	logic       clk_sys;
	logic       resetn;
	logic       selectN;
	logic       serClk;
	logic       addrIn;
	logic       dataOut;
	logic       dataOutOeN;
	logic       eocOut;
	result_type convResult;
	mux_type    muxSelect;
	logic       sampleEn;
	logic       convStart;
	result_type prev;
	int         n_fail;
	int         total_checks;
	int         nStart;
	int         smpCnt;
	int         lowCnt;
	int         lastLow;

	serial_adc_ctrl uut (.clk_sys(clk_sys), .resetn(resetn), .selectN(selectN),
		.serClk(serClk), .addrIn(addrIn), .dataOut(dataOut), .dataOutOeN(dataOutOeN),
		.eocOut(eocOut), .convResult(convResult), .muxSelect(muxSelect),
		.sampleEn(sampleEn), .convStart(convStart));
	host_port host (.clk_sys(clk_sys), .selectN(selectN), .serClk(serClk),
		.addrIn(addrIn), .dataOut(dataOut));

	// system clock
	initial
	begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	// start pulses, sampling cycles and busy time
	always @(posedge clk_sys)
	begin
		nStart <= nStart + int'(convStart === 1'b1);
		smpCnt <= smpCnt + int'(sampleEn === 1'b1);
		lowCnt <= (eocOut === 1'b0) ? lowCnt + 1 : 0;
		if (eocOut === 1'b1 && lowCnt != 0)
			lastLow <= lowCnt;
	end

	task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] seen);
		total_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic waitEoc();
		int c;
		c = 0;
		while (eocOut !== 1'b1 && c < 1100)
		begin
			host.tick(1);
			c++;
		end
		// one more edge so the busy-time counter records the low span
		host.tick(1);
		check("eoc wait", 1, c < 1100);
		check("conv time", 1, lastLow >= `CONV_CYCLES - 3 && lastLow <= `CONV_CYCLES + 3);
		prev = convResult;
	endtask

	// ten clocks, select high between, every address code
	task automatic modeOne();
		int s;
		int m;
		for (int a = 0; a < 16; a++)
		begin
			s = nStart;
			m = smpCnt;
			convResult = {a[3:0], 6'h15};
			host.xfer(a[3:0], 10, 1'b0, 1'b0);
			check("mux", (a < 14) ? 16'h1 << a : 16'h0, muxSelect);
			check("data", prev, host.got[9:0]);
			check("eoc low", 0, eocOut);
			check("start", s + 1, nStart);
			check("sample", 1, smpCnt - m >= 45 && smpCnt - m <= 51);
			check("oe off", 1, dataOutOeN);
			waitEoc();
		end
	endtask

	// sixteen clocks, select high between
	task automatic modeThree();
		convResult = 10'h3c3;
		host.xfer(4'h5, 16, 1'b0, 1'b0);
		check("zeros", {prev, 6'h00}, host.got);
		waitEoc();
	endtask

	// ten clocks, select held low
	task automatic modeTwo();
		convResult = 10'h2e7;
		host.xfer(4'h2, 10, 1'b1, 1'b0);
		check("data", prev, host.got[9:0]);
		waitEoc();
		check("msb at eoc", prev[9], dataOut);
		convResult = 10'h258;
		host.xfer(4'h2, 10, 1'b0, 1'b0);
		check("held data", prev, host.got[9:0]);
		waitEoc();
	endtask

	// sixteen fast clocks, select held low
	task automatic modeFour();
		convResult = 10'h39c;
		host.xfer(4'h9, 16, 1'b1, 1'b0);
		check("fast zeros", {prev, 6'h00}, host.got);
		waitEoc();
		check("msb at done", prev[9], dataOut);
		convResult = 10'h0c3;
		host.xfer(4'h9, 16, 1'b0, 1'b0);
		check("held 16 data", {prev, 6'h00}, host.got);
		waitEoc();
	endtask

	// thirteen slow clocks, select high between
	task automatic modeFive();
		convResult = 10'h2a5;
		host.xfer(4'h4, 13, 1'b0, 1'b1);
		check("slow zeros", {prev, 3'h0}, host.got[12:0]);
		check("slow eoc", 1, eocOut);
		prev = convResult;
		convResult = 10'h0aa;
		host.xfer(4'h4, 10, 1'b0, 1'b0);
		check("slow result", prev, host.got[9:0]);
		waitEoc();
	endtask

	// sixteen slow clocks, select held low
	task automatic modeSix();
		convResult = 10'h2b4;
		host.xfer(4'h7, 16, 1'b1, 1'b1);
		check("zeros", {prev, 6'h00}, host.got);
		check("msb at 16", convResult[9], dataOut);
		check("eoc done", 1, eocOut);
		prev = convResult;
		convResult = 10'h111;
		host.xfer(4'h7, 10, 1'b0, 1'b0);
		check("slow data", prev, host.got[9:0]);
		waitEoc();
	endtask

	// select fall in mid-conversion keeps old result
	task automatic abortRun();
		convResult = 10'h0f0;
		host.xfer(4'h1, 10, 1'b0, 1'b0);
		host.selectN = 1'b0;
		host.tick(8);
		check("abort eoc", 1, eocOut);
		check("oe on", 0, dataOutOeN);
		host.xfer(4'h1, 10, 1'b0, 1'b0);
		check("kept", prev, host.got[9:0]);
		waitEoc();
	endtask

	task automatic complete_run();
		$display("checks %0d failures %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// main sequence
	initial
	begin
		resetn = 1'b0;
		convResult = 10'h000;
		prev = `RESULT_RESET;
		repeat (4) @(posedge clk_sys);
		#1;
		resetn = 1'b1;
		host.tick(4);
		check("reset oe", 1, dataOutOeN);
		modeOne();
		modeThree();
		modeTwo();
		modeFour();
		modeFive();
		modeSix();
		abortRun();
		complete_run();
	end

	// hang guard
	initial
	begin
		#1500000;
		n_fail++;
		complete_run();
	end
endmodule

`default_nettype wire
